/* File: cpfr_defines.vh */
// Constants for the core pointer and flag register block.
// Assumes an 8-bit data path and two data-memory sectors.
`ifndef CPFR_DEFINES_VH
`define CPFR_DEFINES_VH

// Register offsets inside sector 0
`define CPFR_OFS_IND0     8'h00
`define CPFR_OFS_PTR0     8'h01
`define CPFR_OFS_IND1     8'h02
`define CPFR_OFS_PTR1L    8'h03
`define CPFR_OFS_PTR1H    8'h04
`define CPFR_OFS_ACC      8'h05
`define CPFR_OFS_PCLOW    8'h06
`define CPFR_OFS_TBLOW    8'h07
`define CPFR_OFS_TBRES    8'h08
`define CPFR_OFS_TBHIGH   8'h09
`define CPFR_OFS_FLAGS    8'h0a
`define CPFR_OFS_IND2     8'h0c
`define CPFR_OFS_PTR2L    8'h0d
`define CPFR_OFS_PTR2H    8'h0e

// Flag register bit positions
`define CPFR_F_C          0
`define CPFR_F_AC         1
`define CPFR_F_Z          2
`define CPFR_F_OV         3
`define CPFR_F_SLEEP      4
`define CPFR_F_WDTO       5
`define CPFR_F_CZ         6
`define CPFR_F_SC         7

// Reset values and widths
`define CPFR_RST_BYTE     8'h00
`define CPFR_RST_FLAGS    8'h00
`define CPFR_PC_W         12
`define CPFR_PROG_W       16
`define CPFR_DADDR_W      9

// ALU operation codes
`define CPFR_OP_NONE      3'h0
`define CPFR_OP_ADD       3'h1
`define CPFR_OP_ADC       3'h2
`define CPFR_OP_SUB       3'h3
`define CPFR_OP_SBC       3'h4
`define CPFR_OP_LOGIC     3'h5
`define CPFR_OP_RLC       3'h6
`define CPFR_OP_RRC       3'h7

`endif

/* File: cpfr_core_regs.v */
// Core special registers: memory pointers and indirect ports, accumulator,
// program counter low byte, table pointers and the arithmetic/system flags.
// Assumes the instruction decoder drives the strobes below for one cycle
// each, and that general data memory answers combinationally.
//
// Behaviour
// - Indirect port access goes to pointed location
// - Single-byte pointer reaches sector 0 only
// - Wide pointer high byte selects the sector
// - Extended direct access reaches every sector
// - Pointers are ordinary readable writable registers
// - Program counter low write jumps within page
// - Such a jump inserts one dummy cycle
// - Table read: high byte to result register
// - ALU results land in the accumulator
// - Flag writes leave watchdog and sleep flags
// - Watchdog flag: timeout sets, clear/sleep clears
// - Sleep flag: sleep sets, watchdog clear clears
// - Carry from add, no-borrow in subtract, rotates
// - Nibble carry from low nibble in add and subtract only
// - Zero flag marks a zero result
// - Overflow when carry in/out of MSB differ
// - Sign-xor is overflow xor result MSB
// - Chained zero: copy, AND, or hold
// - Flags never pushed automatically to stack
// - Indirect ports read zero, ignore writes through a pointer
`include "cpfr_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module cpfr_core_regs (
	// Clock and reset
	input  wire                        i_clk_sys,
	input  wire                        i_rst,
	// Register port
	input  wire [`CPFR_DADDR_W-1:0]    i_reg_addr,
	input  wire                        i_reg_ext,
	input  wire [7:0]                  i_reg_wdata,
	input  wire                        i_reg_wr,
	input  wire                        i_reg_rd,
	output wire [7:0]                  o_reg_rdata,
	// General data memory
	output wire [`CPFR_DADDR_W-1:0]    o_mem_addr,
	output wire [7:0]                  o_mem_wdata,
	output wire                        o_mem_wr,
	input  wire [7:0]                  i_mem_rdata,
	// ALU operation
	input  wire [2:0]                  i_alu_op,
	input  wire [7:0]                  i_alu_operand,
	output wire [7:0]                  o_acc,
	output wire [7:0]                  o_flags,
	// Program counter
	input  wire                        i_pc_step,
	input  wire                        i_pc_load,
	input  wire [`CPFR_PC_W-1:0]       i_pc_target,
	output wire [`CPFR_PC_W-1:0]       o_pc,
	output wire                        o_dummy_cycle,
	// Table read
	input  wire                        i_tbl_rd,
	output wire [`CPFR_PC_W-1:0]       o_tbl_addr,
	input  wire [`CPFR_PROG_W-1:0]     i_tbl_word,
	output wire [7:0]                  o_tbl_low,
	output wire                        o_tbl_low_valid,
	// System events
	input  wire                        i_wdt_timeout,
	input  wire                        i_watchdog_clear_instruction,
	input  wire                        i_halt
);

	// Stored registers
	reg [7:0]             ptr0_q;
	reg [7:0]             ptr1l_q;
	reg [7:0]             ptr1h_q;
	reg [7:0]             ptr2l_q;
	reg [7:0]             ptr2h_q;
	reg [7:0]             acc_q;
	reg [7:0]             tblow_q;
	reg [7:0]             tbhigh_q;
	reg [7:0]             tbres_q;
	reg [7:0]             flags_q;
	reg [`CPFR_PC_W-1:0]  pc_q;
	reg                   dummy_q;
	reg [7:0]             rdata_q;
	reg [7:0]             tbl_low_q;
	reg                   tbl_low_valid_q;

	// Address resolution
	reg [`CPFR_DADDR_W-1:0] dir_addr;
	reg [`CPFR_DADDR_W-1:0] eff_addr;
	reg                     eff_is_ind;
	reg                     eff_local;
	reg [7:0]               local_rdata;
	wire [7:0]              eff_ofs;

	// Plain instructions see sector 0 only; extended ones carry the sector
	always @* begin
		dir_addr = i_reg_ext ? i_reg_addr
			: {1'b0, i_reg_addr[7:0]};
	end

	// An indirect port is replaced by its pointer; the single-byte pointer
	// is pinned to sector 0 while the wide pointers take their high byte
	always @* begin
		eff_addr = dir_addr;
		if (!dir_addr[8]) begin
			case (dir_addr[7:0])
				`CPFR_OFS_IND0: eff_addr = {1'b0, ptr0_q};
				`CPFR_OFS_IND1: eff_addr = {ptr1h_q[0], ptr1l_q};
				`CPFR_OFS_IND2: eff_addr = {ptr2h_q[0], ptr2l_q};
				default:        eff_addr = dir_addr;
			endcase
		end
	end

	assign eff_ofs = eff_addr[7:0];

	// A pointer that lands on an indirect port again reaches nothing
	always @* begin
		eff_is_ind = !eff_addr[8] && (eff_ofs == `CPFR_OFS_IND0 ||
			eff_ofs == `CPFR_OFS_IND1 || eff_ofs == `CPFR_OFS_IND2);
	end

	// Local decode and read mux
	always @* begin
		eff_local   = !eff_addr[8];
		local_rdata = `CPFR_RST_BYTE;
		case (eff_ofs)
			`CPFR_OFS_IND0,
			`CPFR_OFS_IND1,
			`CPFR_OFS_IND2:   local_rdata = `CPFR_RST_BYTE;
			`CPFR_OFS_PTR0:   local_rdata = ptr0_q;
			`CPFR_OFS_PTR1L:  local_rdata = ptr1l_q;
			`CPFR_OFS_PTR1H:  local_rdata = ptr1h_q;
			`CPFR_OFS_PTR2L:  local_rdata = ptr2l_q;
			`CPFR_OFS_PTR2H:  local_rdata = ptr2h_q;
			`CPFR_OFS_ACC:    local_rdata = acc_q;
			`CPFR_OFS_PCLOW:  local_rdata = pc_q[7:0];
			`CPFR_OFS_TBLOW:  local_rdata = tblow_q;
			`CPFR_OFS_TBRES:  local_rdata = tbres_q;
			`CPFR_OFS_TBHIGH: local_rdata = tbhigh_q;
			`CPFR_OFS_FLAGS:  local_rdata = flags_q;
			default:          eff_local   = 1'b0;
		endcase
	end

	// Write decode, one strobe per register
	wire wr_loc;
	wire wr_ptr0;
	wire wr_ptr1l;
	wire wr_ptr1h;
	wire wr_ptr2l;
	wire wr_ptr2h;
	wire wr_acc;
	wire wr_pcl;
	wire wr_tblow;
	wire wr_tbhigh;
	wire wr_tbres;
	wire wr_flags;

	// A write that resolves onto an indirect port is dropped: the port has
	// no storage, and chaining one pointer through another would hide its target
	assign wr_loc    = i_reg_wr && eff_local && !eff_is_ind;
	assign wr_ptr0   = wr_loc && eff_ofs == `CPFR_OFS_PTR0;
	assign wr_ptr1l  = wr_loc && eff_ofs == `CPFR_OFS_PTR1L;
	assign wr_ptr1h  = wr_loc && eff_ofs == `CPFR_OFS_PTR1H;
	assign wr_ptr2l  = wr_loc && eff_ofs == `CPFR_OFS_PTR2L;
	assign wr_ptr2h  = wr_loc && eff_ofs == `CPFR_OFS_PTR2H;
	assign wr_acc    = wr_loc && eff_ofs == `CPFR_OFS_ACC;
	assign wr_pcl    = wr_loc && eff_ofs == `CPFR_OFS_PCLOW;
	assign wr_tblow  = wr_loc && eff_ofs == `CPFR_OFS_TBLOW;
	assign wr_tbhigh = wr_loc && eff_ofs == `CPFR_OFS_TBHIGH;
	assign wr_tbres  = wr_loc && eff_ofs == `CPFR_OFS_TBRES;
	assign wr_flags  = wr_loc && eff_ofs == `CPFR_OFS_FLAGS;

	// Everything not held here goes to general data memory
	assign o_mem_addr  = eff_addr;
	assign o_mem_wdata = i_reg_wdata;
	assign o_mem_wr    = i_reg_wr && !eff_local;

	// Pointer storage, written like any other register
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			ptr0_q  <= `CPFR_RST_BYTE;
			ptr1l_q <= `CPFR_RST_BYTE;
			ptr1h_q <= `CPFR_RST_BYTE;
			ptr2l_q <= `CPFR_RST_BYTE;
			ptr2h_q <= `CPFR_RST_BYTE;
		end else begin
			if (wr_ptr0)
				ptr0_q <= i_reg_wdata;
			if (wr_ptr1l)
				ptr1l_q <= i_reg_wdata;
			if (wr_ptr1h)
				ptr1h_q <= i_reg_wdata;
			if (wr_ptr2l)
				ptr2l_q <= i_reg_wdata;
			if (wr_ptr2h)
				ptr2h_q <= i_reg_wdata;
		end
	end

	// ALU datapath: operand A is always the accumulator
	// One shared adder serves add and subtract, so in subtraction the carry
	// reads as no-borrow rather than borrow
	reg  [8:0] sum;
	reg  [4:0] nib;
	reg  [7:0] res;
	reg        cin;
	reg        bsub;
	reg  [7:0] opb;
	wire       c7;
	wire       is_arith;
	wire       is_sub;

	assign is_sub   = i_alu_op == `CPFR_OP_SUB || i_alu_op == `CPFR_OP_SBC;
	assign is_arith = is_sub || i_alu_op == `CPFR_OP_ADD || i_alu_op == `CPFR_OP_ADC;

	// Subtract is add of the inverted operand; carry out means no borrow
	always @* begin
		bsub = is_sub;
		opb  = bsub ? ~i_alu_operand : i_alu_operand;
		case (i_alu_op)
			`CPFR_OP_ADC,
			`CPFR_OP_SBC: cin = flags_q[`CPFR_F_C];
			`CPFR_OP_SUB: cin = 1'b1;
			default:      cin = 1'b0;
		endcase
		sum = {1'b0, acc_q} + {1'b0, opb} + {8'h00, cin};
		nib = {1'b0, acc_q[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
		case (i_alu_op)
			`CPFR_OP_LOGIC: res = i_alu_operand;
			`CPFR_OP_RLC:   res = {acc_q[6:0], flags_q[`CPFR_F_C]};
			`CPFR_OP_RRC:   res = {flags_q[`CPFR_F_C], acc_q[7:1]};
			default:        res = sum[7:0];
		endcase
	end

	// Carry into bit 7 recovered from the sum bit
	assign c7 = sum[7] ^ acc_q[7] ^ opb[7];

	// Accumulator: every ALU result lands here; register to register
	// moves have no other path, so they always pass through it
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			acc_q <= `CPFR_RST_BYTE;
		end else if (i_alu_op != `CPFR_OP_NONE) begin
			acc_q <= res;
		end else if (wr_acc) begin
			acc_q <= i_reg_wdata;
		end
	end

	// Flag register. Nothing here feeds a stack: calls and interrupts
	// leave it alone, so software must save it if it matters
	reg [7:0] flags_d;
	reg       ov_n;
	reg       z_n;

	always @* begin
		flags_d = flags_q;
		ov_n    = c7 ^ sum[8];
		z_n     = res == 8'h00;
		if (wr_flags) begin
			flags_d[`CPFR_F_C]  = i_reg_wdata[`CPFR_F_C];
			flags_d[`CPFR_F_AC] = i_reg_wdata[`CPFR_F_AC];
			flags_d[`CPFR_F_Z]  = i_reg_wdata[`CPFR_F_Z];
			flags_d[`CPFR_F_OV] = i_reg_wdata[`CPFR_F_OV];
			flags_d[`CPFR_F_CZ] = i_reg_wdata[`CPFR_F_CZ];
			flags_d[`CPFR_F_SC] = i_reg_wdata[`CPFR_F_SC];
		end
		// An instruction result overrides a same-cycle software write
		if (is_arith) begin
			flags_d[`CPFR_F_C]  = sum[8];
			flags_d[`CPFR_F_AC] = nib[4];
			flags_d[`CPFR_F_Z]  = z_n;
			flags_d[`CPFR_F_OV] = ov_n;
			flags_d[`CPFR_F_SC] = ov_n ^ res[7];
		end
		if (i_alu_op == `CPFR_OP_SUB)
			flags_d[`CPFR_F_CZ] = z_n;
		else if (i_alu_op == `CPFR_OP_SBC)
			flags_d[`CPFR_F_CZ] = flags_q[`CPFR_F_CZ] & z_n;
		if (i_alu_op == `CPFR_OP_LOGIC)
			flags_d[`CPFR_F_Z] = z_n;
		if (i_alu_op == `CPFR_OP_RLC)
			flags_d[`CPFR_F_C] = acc_q[7];
		else if (i_alu_op == `CPFR_OP_RRC)
			flags_d[`CPFR_F_C] = acc_q[0];
		// Hardware sets win over clears arriving in the same cycle
		if (i_halt || i_watchdog_clear_instruction)
			flags_d[`CPFR_F_WDTO] = 1'b0;
		if (i_wdt_timeout)
			flags_d[`CPFR_F_WDTO] = 1'b1;
		if (i_watchdog_clear_instruction)
			flags_d[`CPFR_F_SLEEP] = 1'b0;
		if (i_halt)
			flags_d[`CPFR_F_SLEEP] = 1'b1;
	end

	// Flags leave reset clear so that the first test of any flag is defined
	always @(posedge i_clk_sys) begin
		if (i_rst)
			flags_q <= `CPFR_RST_FLAGS;
		else
			flags_q <= flags_d;
	end

	// Program counter: a low-byte write keeps the page bits and
	// costs one dummy cycle before the target executes
	// A jump to another page has to use the decoder's full load path
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			pc_q    <= {`CPFR_PC_W{1'b0}};
			dummy_q <= 1'b0;
		end else begin
			dummy_q <= wr_pcl;
			if (wr_pcl)
				pc_q <= {pc_q[`CPFR_PC_W-1:8], i_reg_wdata};
			else if (i_pc_load)
				pc_q <= i_pc_target;
			else if (i_pc_step && !dummy_q)
				pc_q <= pc_q + {{(`CPFR_PC_W-1){1'b0}}, 1'b1};
		end
	end

	// Table pointers and result; the low byte leaves through a port so
	// the decoder can store it wherever the instruction names
	// Only the low bits of the high pointer fit the program counter width
	assign o_tbl_addr = {tbhigh_q[`CPFR_PC_W-9:0], tblow_q};

	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			tblow_q         <= `CPFR_RST_BYTE;
			tbhigh_q        <= `CPFR_RST_BYTE;
			tbres_q         <= `CPFR_RST_BYTE;
			tbl_low_q       <= `CPFR_RST_BYTE;
			tbl_low_valid_q <= 1'b0;
		end else begin
			tbl_low_valid_q <= i_tbl_rd;
			if (wr_tblow)
				tblow_q <= i_reg_wdata;
			if (wr_tbhigh)
				tbhigh_q <= i_reg_wdata;
			if (i_tbl_rd) begin
				tbres_q   <= i_tbl_word[15:8];
				tbl_low_q <= i_tbl_word[7:0];
			end else if (wr_tbres) begin
				tbres_q <= i_reg_wdata;
			end
		end
	end

	// Read data stands the cycle after the strobe
	// Local registers win over memory; memory data must already be settled
	// for the resolved address at the edge that samples the strobe
	always @(posedge i_clk_sys) begin
		if (i_rst)
			rdata_q <= `CPFR_RST_BYTE;
		else if (i_reg_rd)
			rdata_q <= eff_local ? local_rdata : i_mem_rdata;
	end

	// Outputs
	assign o_reg_rdata     = rdata_q;
	assign o_acc           = acc_q;
	assign o_flags         = flags_q;
	assign o_pc            = pc_q;
	assign o_dummy_cycle   = dummy_q;
	assign o_tbl_low       = tbl_low_q;
	assign o_tbl_low_valid = tbl_low_valid_q;

endmodule

`default_nettype wire

/* File: cpfr_core_regs_assertions.sv */
// Checker for the core pointer and flag register block, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`include "cpfr_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module cpfr_core_regs_chk (
	// Clock and reset
	input wire                     i_clk_sys,
	input wire                     i_rst,
	// Register port and ALU
	input wire [`CPFR_DADDR_W-1:0] i_reg_addr,
	input wire                     i_reg_ext,
	input wire [7:0]               i_reg_wdata,
	input wire                     i_reg_wr,
	input wire [2:0]               i_alu_op,
	input wire [7:0]               o_acc,
	input wire [7:0]               o_flags,
	// Program counter, table, events
	input wire                     i_pc_load,
	input wire [`CPFR_PC_W-1:0]    o_pc,
	input wire                     o_dummy_cycle,
	input wire                     i_tbl_rd,
	input wire [`CPFR_PROG_W-1:0]  i_tbl_word,
	input wire [7:0]               o_tbl_low,
	input wire                     o_tbl_low_valid,
	input wire                     i_wdt_timeout,
	input wire                     i_watchdog_clear_instruction,
	input wire                     i_halt
);
	default clocking dc @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// Direct writes to sector-0 registers; extended sector-1 writes miss them
	wire loc_wr = i_reg_wr && !(i_reg_ext && i_reg_addr[8]);
	wire pcl_wr = loc_wr && i_reg_addr[7:0] == `CPFR_OFS_PCLOW;
	wire flg_wr = loc_wr && i_reg_addr[7:0] == `CPFR_OFS_FLAGS;
	wire quiet  = !i_wdt_timeout && !i_watchdog_clear_instruction && !i_halt;
	property p_pcl; pcl_wr |=> o_pc == {$past(o_pc[11:8]), $past(i_reg_wdata)}; endproperty
	a_pcl: assert property (p_pcl) else $error("pc low write jump wrong");
	property p_dummy; pcl_wr |=> o_dummy_cycle ##1 (!o_dummy_cycle || $past(i_reg_wr)); endproperty
	a_dummy: assert property (p_dummy) else $error("dummy cycle missing");
	property p_hold; o_dummy_cycle && !i_reg_wr && !i_pc_load |=> $stable(o_pc); endproperty
	a_hold: assert property (p_hold) else $error("pc moved in dummy cycle");
	property p_ro; flg_wr && quiet |=> o_flags[5:4] == $past(o_flags[5:4]); endproperty
	a_ro: assert property (p_ro) else $error("read-only flags changed");
	property p_wdto; i_wdt_timeout |=> o_flags[5]; endproperty
	a_wdto: assert property (p_wdto) else $error("timeout flag not set");
	property p_clr; i_watchdog_clear_instruction && !i_wdt_timeout && !i_halt |=> o_flags[5:4] == 2'b00; endproperty
	a_clr: assert property (p_clr) else $error("watchdog clear wrong");
	property p_halt; i_halt && !i_wdt_timeout |=> o_flags[5:4] == 2'b01; endproperty
	a_halt: assert property (p_halt) else $error("sleep flags wrong");
	property p_sc; i_alu_op inside {[`CPFR_OP_ADD:`CPFR_OP_SBC]} |=> o_flags[7] == (o_flags[3] ^ o_acc[7]); endproperty
	a_sc: assert property (p_sc) else $error("sign xor flag wrong");
	property p_cz; i_alu_op == `CPFR_OP_SUB |=> o_flags[6] == o_flags[2]; endproperty
	a_cz: assert property (p_cz) else $error("chained zero wrong");
	property p_zero; i_alu_op != `CPFR_OP_NONE && i_alu_op < `CPFR_OP_RLC |=> o_flags[2] == (o_acc == 8'h00); endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_tbl; i_tbl_rd |=> o_tbl_low_valid && o_tbl_low == $past(i_tbl_word[7:0]); endproperty
	a_tbl: assert property (p_tbl) else $error("table low byte wrong");
	c_dummy: cover property (o_dummy_cycle);
	c_tbl: cover property (o_tbl_low_valid);
	c_both: cover property (o_flags[5:4] == 2'b11);
endmodule
bind cpfr_core_regs cpfr_core_regs_chk u_chk (.*);
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the core pointer and flag register block.
// Assumes registers are zero after reset; data memory is modelled here.
`include "cpfr_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam [10:0] N = 11'h000;
	logic        i_clk_sys = 1'b0;
	logic        i_rst = 1'b1;
	logic [8:0]  i_reg_addr = 9'h000;
	logic        i_reg_ext = 1'b0;
	logic [7:0]  i_reg_wdata = 8'h00;
	logic        i_reg_wr = 1'b0;
	logic        i_reg_rd = 1'b0;
	logic [2:0]  i_alu_op = 3'h0;
	logic [7:0]  i_alu_operand = 8'h00;
	logic        i_pc_step = 1'b0;
	logic        i_pc_load = 1'b0;
	logic [11:0] i_pc_target = 12'h000;
	logic        i_tbl_rd = 1'b0;
	logic        i_wdt_timeout = 1'b0;
	logic        i_watchdog_clear_instruction = 1'b0;
	logic        i_halt = 1'b0;
	wire  [7:0]  o_reg_rdata, o_mem_wdata, o_acc, o_flags, o_tbl_low;
	wire  [8:0]  o_mem_addr;
	wire  [11:0] o_pc, o_tbl_addr;
	wire         o_mem_wr, o_dummy_cycle, o_tbl_low_valid;
	int          fails = 0;
	int          tests_run = 0;
	// Memory content differs per sector so a wrong sector shows
	function automatic [7:0] mem(input [8:0] a);
		mem = a[7:0] ^ {a[8], 7'h2a};
	endfunction
	wire  [7:0]  i_mem_rdata = mem(o_mem_addr);
	// Program memory word carries its own address, so a wrong pointer shows
	wire  [15:0] i_tbl_word = {4'hb, o_tbl_addr};
	cpfr_core_regs dut (.*);
	always #5 i_clk_sys = ~i_clk_sys;
	task automatic chk(input string n, input [11:0] e, input [11:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// Address argument carries the extended bit on top
	task automatic wr(input [9:0] a, input [7:0] d, input [10:0] em);
		@(posedge i_clk_sys);
		{i_reg_ext, i_reg_addr} <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		#1;
		if (em[10]) chk("mem_port", em[9:0], {o_mem_wr, o_mem_addr});
		if (em[10]) chk("mem_wdata", d, o_mem_wdata);
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd(input [9:0] a, input [7:0] e, input [10:0] em);
		@(posedge i_clk_sys);
		{i_reg_ext, i_reg_addr} <= a;
		i_reg_rd <= 1'b1;
		#1;
		if (em[10]) chk("mem_port", em[9:0], {o_mem_wr, o_mem_addr});
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", e, o_reg_rdata);
	endtask
	task automatic alu(input [2:0] op, input [7:0] b, input [7:0] ea, input [7:0] ef);
		@(posedge i_clk_sys);
		i_alu_op <= op;
		i_alu_operand <= b;
		@(posedge i_clk_sys);
		i_alu_op <= 3'h0;
		#1;
		chk("acc", ea, o_acc);
		chk("flags", ef, o_flags);
	endtask
	// Event vector is timeout, watchdog clear, halt
	task automatic ev(input [2:0] v, input [7:0] ef);
		@(posedge i_clk_sys);
		{i_wdt_timeout, i_watchdog_clear_instruction, i_halt} <= v;
		@(posedge i_clk_sys);
		{i_wdt_timeout, i_watchdog_clear_instruction, i_halt} <= 3'h0;
		#1;
		chk("flags", ef, o_flags);
	endtask
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog: the tests need well under a thousand cycles
	initial begin
		#200000;
		fails++;
		wrap_up;
	end
	initial begin
		repeat (16) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		#1;
		chk("flags", 12'h000, o_flags);
		wr(10'h001, 8'hf0, N);
		rd(10'h001, 8'hf0, N);
		rd(10'h000, mem(9'h0f0), {2'b10, 9'h0f0});
		wr(10'h004, 8'h01, N);
		wr(10'h003, 8'h40, N);
		rd(10'h004, 8'h01, N);
		rd(10'h002, mem(9'h140), {2'b10, 9'h140});
		wr(10'h00e, 8'h01, N);
		wr(10'h00d, 8'h33, N);
		wr(10'h00c, 8'ha5, {2'b11, 9'h133});
		wr(10'h001, 8'h02, N);
		wr(10'h000, 8'h77, {2'b10, 9'h002});
		rd(10'h000, 8'h00, N);
		rd(10'h3f0, mem(9'h1f0), {2'b10, 9'h1f0});
		rd(10'h1f0, mem(9'h0f0), {2'b10, 9'h0f0});
		rd(10'h00b, mem(9'h00b), {2'b10, 9'h00b});
		done("pointers");
		alu(`CPFR_OP_LOGIC, 8'h7f, 8'h7f, 8'h00);
		alu(`CPFR_OP_ADD, 8'h01, 8'h80, 8'h0a);
		alu(`CPFR_OP_SUB, 8'h80, 8'h00, 8'h47);
		alu(`CPFR_OP_SBC, 8'h01, 8'hff, 8'h80);
		alu(`CPFR_OP_RLC, 8'h00, 8'hfe, 8'h81);
		alu(`CPFR_OP_RRC, 8'h00, 8'hff, 8'h80);
		alu(`CPFR_OP_ADC, 8'h01, 8'h00, 8'h07);
		rd(10'h005, 8'h00, N);
		done("alu");
		wr(10'h00a, 8'h00, N);
		ev(3'b001, 8'h10);
		ev(3'b100, 8'h30);
		wr(10'h00a, 8'hcf, N);
		rd(10'h00a, 8'hff, N);
		wr(10'h00a, 8'h00, N);
		rd(10'h00a, 8'h30, N);
		ev(3'b001, 8'h10);
		ev(3'b010, 8'h00);
		wr(10'h00a, 8'h30, N);
		rd(10'h00a, 8'h00, N);
		done("flags");
		@(posedge i_clk_sys);
		i_pc_target <= 12'ha00;
		i_pc_load <= 1'b1;
		@(posedge i_clk_sys);
		i_pc_load <= 1'b0;
		wr(10'h006, 8'h34, N);
		i_pc_step <= 1'b1;
		#1;
		chk("pc", 12'ha34, o_pc);
		chk("dummy", 12'h001, o_dummy_cycle);
		@(posedge i_clk_sys);
		#1;
		chk("pc", 12'ha34, o_pc);
		chk("dummy", 12'h000, o_dummy_cycle);
		@(posedge i_clk_sys);
		i_pc_step <= 1'b0;
		#1;
		chk("pc", 12'ha35, o_pc);
		done("pc");
		wr(10'h007, 8'h12, N);
		wr(10'h009, 8'h05, N);
		#1;
		chk("tbl_addr", 12'h512, o_tbl_addr);
		@(posedge i_clk_sys);
		i_tbl_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_tbl_rd <= 1'b0;
		#1;
		chk("tbl_low", 12'h112, {o_tbl_low_valid, o_tbl_low});
		rd(10'h008, 8'hb5, N);
		done("table");
		wrap_up;
	end
endmodule
`default_nettype wire
